// *** rtl/isa_slave_pkg.sv ***
// constants, pin carriers and state types of the ISA slave port
// How it works
// - I/O decode uses address lines 0..15 only
// - memory decode uses 20 lines plus chip-select
// - 16-bit data bus, floated unless driving reads
// - reset pin qualified after 400 ns steady
// - no slave I/O while address enable high
// - test low turns address enable into scan clock
// - low memory-read strobe means memory read
// - low memory-write strobe means memory write
// - memory chip-select only with memory space enabled
// - memory chip-select open drain, floats when idle
// - four interrupts, three DMA, one interrupt and at most one DMA selected
// - memory cycles need no added wait states
// - 4-Kbyte frame page via memory, I/O, DMA
// - refresh low ignores strobes and DMA acknowledges
// - I/O chip-select open drain on I/O hit
// - I/O read drives register, write stores it; status is read-only, data port reads and writes the page
package isa_slave_pkg;

    localparam int CLK_PERIOD_PS    = 8000;
    localparam int RESET_STABLE_NS  = 400;
    localparam int RESET_STABLE_CYC =
        (RESET_STABLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    localparam int DATA_W      = 16;
    localparam int IRQ_CNT     = 4;
    localparam int DMA_CNT     = 3;
    localparam int IO_REG_CNT  = 8;
    localparam int PAGE_BYTES  = 4096;
    localparam int PAGE_WORDS  = PAGE_BYTES / 2;
    localparam int PAGE_AW     = 11;

    localparam logic [15:0] IO_BASE_DEF  = 16'h0300;
    localparam logic [19:0] MEM_BASE_DEF = 20'hD0000;

    // word offsets inside the 16-byte I/O window
    localparam logic [2:0] BUS_CTL_IDX = 3'h1;
    localparam logic [2:0] SELECT_IDX  = 3'h2;
    localparam logic [2:0] STATUS_IDX  = 3'h3;
    localparam logic [2:0] PTR_IDX     = 3'h4;
    localparam logic [2:0] DATA_IDX    = 3'h5;

    localparam int MEM_SPACE_EN_BIT = 10;
    localparam int IRQ_SEL_LSB      = 0;
    localparam int DMA_SEL_LSB      = 4;

    localparam logic [15:0] BUS_CTL_RST = 16'h0000;
    localparam logic [15:0] SELECT_RST  = 16'h0030;

    typedef struct packed {
        logic [19:0] sa;
        logic [15:0] sd;
        logic        memR_n;
        logic        memW_n;
        logic        ioR_n;
        logic        ioW_n;
        logic        aen;
        logic        refresh_n;
        logic        sbhe_n;
        logic        chipSel_n;
        logic        test_n;
        logic [2:0]  dmack_n;
    } isaPins_t;

    typedef enum logic [1:0] {
        ARM_WAIT_LOW,
        ARM_WAIT_HIGH,
        ARM_DONE
    } armState_t;

    typedef struct packed {
        logic [IO_REG_CNT-1:0][15:0] ioRegs;
        logic [15:0]                 sdOut;
        logic                        sdOe;
        logic                        memCs16Oe;
        logic                        ioCs16Oe;
        logic [IRQ_CNT-1:0]          irqOut;
        logic [IRQ_CNT-1:0]          irqOe;
        logic [DMA_CNT-1:0]          dmaOut;
        logic [DMA_CNT-1:0]          dmaOe;
        logic                        scanClk;
        logic                        portPrev;
        armState_t                   arm;
    } slaveState_t;

    typedef struct packed {
        logic                                 sync1;
        logic                                 sync2;
        logic [$clog2(RESET_STABLE_CYC+1)-1:0] cnt;
        logic                                 valid;
    } rstQualState_t;

endpackage

// *** rtl/pin_sync.sv ***
// two-flop synchroniser for a bundle of bus pins
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } syncState_t;

    syncState_t q;
    syncState_t d;

    always_comb begin
        d    = q;
        d.s1 = din;
        d.s2 = q.s1;
    end

    // strobes idle high, so reset to all ones keeps them inactive
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '1;
        end else begin
            q <= d;
        end
    end

    assign dout = q.s2;
endmodule

// *** rtl/reset_qualifier.sv ***
// qualifies the active-high bus reset pin and releases it on a clock
`timescale 1ns/1ps
module reset_qualifier (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic resetPin,
    output logic      busReset
);
    localparam int CW = $clog2(isa_slave_pkg::RESET_STABLE_CYC + 1);
    localparam logic [CW-1:0] CNT_MAX =
        CW'(isa_slave_pkg::RESET_STABLE_CYC);

    isa_slave_pkg::rstQualState_t q;
    isa_slave_pkg::rstQualState_t d;

    always_comb begin
        d       = q;
        d.sync1 = resetPin;
        d.sync2 = q.sync1;
        // a glitch shorter than the window restarts the count
        if (!q.sync2) begin
            d.cnt   = '0;
            d.valid = 1'b0;
        end else if (q.cnt != CNT_MAX) begin
            d.cnt = q.cnt + CW'(1);
        end else begin
            d.valid = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign busReset = q.valid;

    property p_resetStable;
        @(posedge clk) disable iff (!arst_n)
        $rose(q.valid) |-> $past(q.sync2, 1) && $past(q.sync2, 50);
    endproperty
    a_resetStable: assert property (p_resetStable)
        else $error("reset qualified before 400 ns of steady input");

    property p_resetDrops;
        @(posedge clk) disable iff (!arst_n)
        !q.sync2 |=> !q.valid;
    endproperty
    a_resetDrops: assert property (p_resetDrops)
        else $error("qualified reset outlived its pin");
endmodule

// *** rtl/isa_slave_bus_interface.sv ***
// ISA slave port: decode, register window, frame page and pin drivers
`timescale 1ns/1ps
module isa_slave_bus_interface #(
    parameter logic [15:0] IO_BASE  = isa_slave_pkg::IO_BASE_DEF,
    parameter logic [19:0] MEM_BASE = isa_slave_pkg::MEM_BASE_DEF
) (
    input  wire logic                     clk,
    input  wire logic                     arst_n,
    input  wire isa_slave_pkg::isaPins_t  pinsIn,
    input  wire logic                     resetPin,
    input  wire logic                     irqEvent,
    input  wire logic                     dmaWant,
    output logic [15:0]                   sdOut,
    output logic                          sdOe,
    output logic                          memCs16Out,
    output logic                          memCs16Oe,
    output logic                          ioCs16Out,
    output logic                          ioCs16Oe,
    output logic                          chRdyOut,
    output logic                          chRdyOe,
    output logic [isa_slave_pkg::IRQ_CNT-1:0] irqOut,
    output logic [isa_slave_pkg::IRQ_CNT-1:0] irqOe,
    output logic [isa_slave_pkg::DMA_CNT-1:0] dmaReqOut,
    output logic [isa_slave_pkg::DMA_CNT-1:0] dmaReqOe,
    output logic                          scanShiftClk,
    output logic                          coreReset
);
    localparam int AW = isa_slave_pkg::PAGE_AW;

    // both resets must leave the select register on no DMA channel
    function automatic isa_slave_pkg::slaveState_t resetImage();
        resetImage = '0;
        resetImage.ioRegs[isa_slave_pkg::SELECT_IDX] =
            isa_slave_pkg::SELECT_RST;
        resetImage.ioRegs[isa_slave_pkg::BUS_CTL_IDX] =
            isa_slave_pkg::BUS_CTL_RST;
    endfunction

    localparam isa_slave_pkg::slaveState_t RST_STATE = resetImage();

    isa_slave_pkg::isaPins_t    pins;
    isa_slave_pkg::slaveState_t q;
    isa_slave_pkg::slaveState_t d;
    logic                       busReset;
    logic                       resetQ;

    logic [15:0]   page [isa_slave_pkg::PAGE_WORDS];
    logic          pageWe;
    logic [AW-1:0] pageAddr;
    logic [1:0]    pageBe;

    logic          normalMode;
    logic          refOk;
    logic          ioRd;
    logic          ioWr;
    logic          memRd;
    logic          memWr;
    logic          ioHit;
    logic          memHit;
    logic          memEn;
    logic [2:0]    ioIdx;
    logic [1:0]    irqSel;
    logic [1:0]    dmaSel;
    logic          dmaAck;
    logic          portActive;
    logic [AW-1:0] ptrWord;
    logic [1:0]    busBe;

    pin_sync #(
        .W($bits(isa_slave_pkg::isaPins_t))
    ) uPins (
        .clk   (clk),
        .arst_n(arst_n),
        .din   (pinsIn),
        .dout  (pins)
    );

    reset_qualifier uRst (
        .clk     (clk),
        .arst_n  (arst_n),
        .resetPin(resetPin),
        .busReset(busReset)
    );

    function automatic logic [1:0] selField(input logic [15:0] r,
                                            input int          lsb);
        selField = r[lsb +: 2];
    endfunction

    function automatic logic [15:0] mergeBytes(input logic [15:0] old,
                                               input logic [15:0] nw,
                                               input logic [1:0]  be);
        mergeBytes = {be[1] ? nw[15:8] : old[15:8],
                      be[0] ? nw[7:0]  : old[7:0]};
    endfunction

    // refresh low masks every strobe and acknowledge
    assign refOk      = pins.refresh_n;
    assign normalMode = pins.test_n;
    assign ioRd       = !pins.ioR_n && refOk;
    assign ioWr       = !pins.ioW_n && refOk;
    assign memRd      = !pins.memR_n && refOk;
    assign memWr      = !pins.memW_n && refOk;
    assign ioIdx      = pins.sa[3:1];
    assign busBe      = {!pins.sbhe_n, !pins.sa[0]};

    // slave I/O only while the DMA controller does not own the bus
    assign ioHit = normalMode && !pins.aen && q.arm == isa_slave_pkg::ARM_DONE
                   && pins.sa[15:4] == IO_BASE[15:4];
    assign memEn = q.ioRegs[isa_slave_pkg::BUS_CTL_IDX]
                           [isa_slave_pkg::MEM_SPACE_EN_BIT];
    assign memHit = memEn && !pins.chipSel_n
                    && q.arm == isa_slave_pkg::ARM_DONE
                    && pins.sa[19:12] == MEM_BASE[19:12];

    assign irqSel = selField(q.ioRegs[isa_slave_pkg::SELECT_IDX],
                             isa_slave_pkg::IRQ_SEL_LSB);
    assign dmaSel = selField(q.ioRegs[isa_slave_pkg::SELECT_IDX],
                             isa_slave_pkg::DMA_SEL_LSB);
    // dmaSel of 3 means no channel; acknowledges then mean nothing
    assign dmaAck = normalMode && pins.aen && refOk
                    && ((dmaSel == 2'h0 && !pins.dmack_n[0])
                     || (dmaSel == 2'h1 && !pins.dmack_n[1])
                     || (dmaSel == 2'h2 && !pins.dmack_n[2]));
    assign ptrWord = q.ioRegs[isa_slave_pkg::PTR_IDX][AW:1];
    assign portActive = (ioHit && ioIdx == isa_slave_pkg::DATA_IDX
                         && (ioRd || ioWr)) || (dmaAck && (ioRd || ioWr));

    // write path into the frame page: memory space, data port or DMA
    always_comb begin
        pageWe   = 1'b0;
        pageAddr = ptrWord;
        pageBe   = 2'b11;
        if (memHit && memWr) begin
            pageWe   = 1'b1;
            pageAddr = pins.sa[AW:1];
            pageBe   = busBe;
        end else if (dmaAck && ioWr) begin
            pageWe = 1'b1;
        end else if (ioHit && ioWr && ioIdx == isa_slave_pkg::DATA_IDX) begin
            pageWe = 1'b1;
            pageBe = busBe;
        end
    end

    always_ff @(posedge clk) begin
        if (pageWe) begin
            page[pageAddr] <= mergeBytes(page[pageAddr], pins.sd, pageBe);
        end
    end

    always_comb begin
        d = q;
        d.sdOe      = 1'b0;
        d.sdOut     = q.sdOut;
        d.ioCs16Oe  = ioHit;
        d.memCs16Oe = memHit;
        d.scanClk   = !normalMode && pins.aen;
        d.portPrev  = portActive;

        // reads: data leaves the bus as soon as the strobe ends
        if (memHit && memRd) begin
            d.sdOe  = 1'b1;
            d.sdOut = page[pins.sa[AW:1]];
        end else if (dmaAck && ioRd) begin
            d.sdOe  = 1'b1;
            d.sdOut = page[ptrWord];
        end else if (ioHit && ioRd) begin
            d.sdOe = 1'b1;
            case (ioIdx)
                isa_slave_pkg::DATA_IDX: begin
                    d.sdOut = page[ptrWord];
                end
                isa_slave_pkg::STATUS_IDX: begin
                    d.sdOut = {12'h000, dmaWant, irqEvent, memEn,
                               q.arm == isa_slave_pkg::ARM_DONE};
                end
                default: begin
                    d.sdOut = q.ioRegs[ioIdx];
                end
            endcase
        end

        // register writes repeat harmlessly while the strobe is low
        if (ioHit && ioWr && ioIdx != isa_slave_pkg::DATA_IDX
            && ioIdx != isa_slave_pkg::STATUS_IDX) begin
            d.ioRegs[ioIdx] = mergeBytes(q.ioRegs[ioIdx], pins.sd,
                                         busBe);
        end

        // pointer steps one word when a port or DMA transfer ends
        if (q.portPrev && !portActive) begin
            d.ioRegs[isa_slave_pkg::PTR_IDX] =
                q.ioRegs[isa_slave_pkg::PTR_IDX] + 16'h0002;
        end

        for (int i = 0; i < isa_slave_pkg::IRQ_CNT; i++) begin
            d.irqOe[i]  = irqSel == 2'(i);
            d.irqOut[i] = irqSel == 2'(i) && irqEvent;
        end
        for (int i = 0; i < isa_slave_pkg::DMA_CNT; i++) begin
            d.dmaOe[i]  = dmaSel == 2'(i);
            d.dmaOut[i] = dmaSel == 2'(i) && dmaWant;
        end

        // host must swing high-byte enable low then high after reset
        case (q.arm)
            isa_slave_pkg::ARM_WAIT_LOW: begin
                if (!pins.sbhe_n) begin
                    d.arm = isa_slave_pkg::ARM_WAIT_HIGH;
                end
            end
            isa_slave_pkg::ARM_WAIT_HIGH: begin
                if (pins.sbhe_n) begin
                    d.arm = isa_slave_pkg::ARM_DONE;
                end
            end
            isa_slave_pkg::ARM_DONE: begin
                d.arm = isa_slave_pkg::ARM_DONE;
            end
            default: begin
                d.arm = isa_slave_pkg::ARM_WAIT_LOW;
            end
        endcase

        if (busReset) begin
            d = RST_STATE;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q      <= RST_STATE;
            resetQ <= 1'b0;
        end else begin
            q      <= d;
            resetQ <= busReset;
        end
    end

    assign sdOut        = q.sdOut;
    assign sdOe         = q.sdOe;
    assign memCs16Out   = 1'b0;
    assign memCs16Oe    = q.memCs16Oe;
    assign ioCs16Out    = 1'b0;
    assign ioCs16Oe     = q.ioCs16Oe;
    // no wait states: ready is never pulled, pin always floats
    assign chRdyOut     = 1'b0;
    assign chRdyOe      = 1'b0;
    assign irqOut       = q.irqOut;
    assign irqOe        = q.irqOe;
    assign dmaReqOut    = q.dmaOut;
    assign dmaReqOe     = q.dmaOe;
    assign scanShiftClk = q.scanClk;
    assign coreReset    = resetQ;

    property p_aenBlocksIo;
        @(posedge clk) disable iff (!arst_n)
        pins.aen && pins.test_n |=> !ioCs16Oe;
    endproperty
    a_aenBlocksIo: assert property (p_aenBlocksIo)
        else $error("I/O select asserted while address enable high");

    property p_refreshQuiet;
        @(posedge clk) disable iff (!arst_n)
        !pins.refresh_n |=> !sdOe;
    endproperty
    a_refreshQuiet: assert property (p_refreshQuiet)
        else $error("data driven during refresh");

    property p_memCsEnabled;
        @(posedge clk) disable iff (!arst_n)
        memCs16Oe |-> $past(memEn) && !$past(pins.chipSel_n);
    endproperty
    a_memCsEnabled: assert property (p_memCsEnabled)
        else $error("memory select without enable and chip-select");

    property p_releaseOnIdle;
        @(posedge clk) disable iff (!arst_n)
        pins.ioR_n && pins.memR_n |=> !sdOe;
    endproperty
    a_releaseOnIdle: assert property (p_releaseOnIdle)
        else $error("data bus held after read strobes ended");

    property p_readDrives;
        @(posedge clk) disable iff (!arst_n)
        memHit && memRd && !busReset |=> sdOe ##1 1'b1;
    endproperty
    a_readDrives: assert property (p_readDrives)
        else $error("memory read not driven on data bus");

    property p_scanClock;
        @(posedge clk) disable iff (!arst_n)
        !pins.test_n && !busReset |=> scanShiftClk == $past(pins.aen);
    endproperty
    a_scanClock: assert property (p_scanClock)
        else $error("scan clock does not follow address enable");

    property p_ioWindow;
        @(posedge clk) disable iff (!arst_n)
        ioCs16Oe |-> $past(pins.sa[15:4]) == IO_BASE[15:4];
    endproperty
    a_ioWindow: assert property (p_ioWindow)
        else $error("I/O select outside the assigned window");

    property p_armGate;
        @(posedge clk) disable iff (!arst_n)
        q.arm != isa_slave_pkg::ARM_DONE |=> !ioCs16Oe && !memCs16Oe;
    endproperty
    a_armGate: assert property (p_armGate)
        else $error("access answered before high-byte toggle");

    property p_oneIrq;
        @(posedge clk) disable iff (!arst_n)
        $onehot0(irqOe) && $onehot0(dmaReqOe);
    endproperty
    a_oneIrq: assert property (p_oneIrq)
        else $error("more than one request line enabled");
endmodule

// *** verif/isa_host_model.sv ***
// ISA host model: drives the bus pads and resolves the shared data lines
`timescale 1ns/1ps
module isa_host_model (
    input  wire logic                clk,
    input  wire logic [15:0]         sdOut,
    input  wire logic                sdOe,
    input  wire logic                memCs16Oe,
    input  wire logic                ioCs16Oe,
    output isa_slave_pkg::isaPins_t  pins
);
    isa_slave_pkg::isaPins_t drv;
    logic [15:0]             hostSd;
    logic                    hostSdEn;
    logic [15:0]             lastSd = 16'h0000;

    // released bus shows the inverse of its last value, never a held copy
    always_comb begin
        pins = drv;
        pins.sd = sdOe ? sdOut : (hostSdEn ? hostSd : ~lastSd);
    end

    always @(posedge clk) begin
        if (sdOe || hostSdEn) begin
            lastSd <= pins.sd;
        end
    end

    initial begin
        drv = '{sa: 20'h00000, sd: 16'h0000, memR_n: 1'b1, memW_n: 1'b1,
                ioR_n: 1'b1, ioW_n: 1'b1, aen: 1'b0, refresh_n: 1'b1,
                sbhe_n: 1'b1, chipSel_n: 1'b1, test_n: 1'b1,
                dmack_n: 3'h7};
        hostSd = 16'h0000;
        hostSdEn = 1'b0;
    end

    // high-byte enable high, low, high before the first access
    task automatic arm();
        @(negedge clk);
        drv.sbhe_n = 1'b0;
        repeat (4) @(negedge clk);
        drv.sbhe_n = 1'b1;
        repeat (4) @(negedge clk);
    endtask

    // op: 0 io read, 1 io write, 2 memory read, 3 memory write
    // flags: aen, refresh_n, test_n, chipSel_n
    task automatic access(input logic [1:0] op, input logic [19:0] addr,
                          input logic [3:0] flags, input logic [15:0] wd,
                          output logic [15:0] rd, output logic oe,
                          output logic cs, output logic relOe);
        @(negedge clk);
        drv.sa = addr;
        drv.aen = flags[3];
        drv.refresh_n = flags[2];
        drv.test_n = flags[1];
        drv.chipSel_n = flags[0];
        drv.sbhe_n = 1'b0;
        hostSd = wd;
        hostSdEn = op[0];
        drv.ioR_n = (op != 2'h0);
        drv.ioW_n = (op != 2'h1);
        drv.memR_n = (op != 2'h2);
        drv.memW_n = (op != 2'h3);
        repeat (5) @(negedge clk);
        rd = sdOut;
        oe = sdOe;
        cs = op[1] ? memCs16Oe : ioCs16Oe;
        drv.ioR_n = 1'b1;
        drv.ioW_n = 1'b1;
        drv.memR_n = 1'b1;
        drv.memW_n = 1'b1;
        // data and qualifiers held past the strobe so the write lands whole
        repeat (5) @(negedge clk);
        relOe = sdOe;
        hostSdEn = 1'b0;
        drv.sa = 20'h00000;
        drv.aen = 1'b0;
        drv.refresh_n = 1'b1;
        drv.test_n = 1'b1;
        drv.chipSel_n = 1'b1;
        drv.sbhe_n = 1'b1;
        // selects follow the address, so they drop only once it leaves
        repeat (4) @(negedge clk);
        relOe = relOe | memCs16Oe | ioCs16Oe;
    endtask
endmodule

// *** verif/isa_slave_bus_interface_bench.sv ***
// self-checking bench for the ISA slave port
`timescale 1ns/1ps
`define CHECK(got, exp) \
    begin \
        samplesChecked++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("unexpected at %0t: got %h expected %h", \
                     $time, got, exp); \
        end \
    end
module isa_slave_bus_interface_bench;
    localparam logic [19:0] IOB   = {4'h0, isa_slave_pkg::IO_BASE_DEF};
    localparam logic [19:0] MB    = isa_slave_pkg::MEM_BASE_DEF;
    localparam int          LIMIT = 3000;

    typedef struct packed {
        logic [1:0]  op;
        logic [19:0] addr;
        logic [3:0]  flags;
        logic [15:0] data;
        logic        hit;
        logic        sel;
    } row_t;

    logic                    clk = 1'b0;
    logic                    arst_n;
    logic                    resetPin;
    logic                    irqEvent;
    logic                    dmaWant;
    isa_slave_pkg::isaPins_t pins;
    logic [15:0]             sdOut;
    logic                    sdOe;
    logic                    memCs16Out;
    logic                    memCs16Oe;
    logic                    ioCs16Out;
    logic                    ioCs16Oe;
    logic                    chRdyOut;
    logic                    chRdyOe;
    logic [3:0]              irqOut;
    logic [3:0]              irqOe;
    logic [2:0]              dmaReqOut;
    logic [2:0]              dmaReqOe;
    logic                    scanShiftClk;
    logic                    coreReset;
    int                      mismatches = 0;
    int                      samplesChecked = 0;
    int                      cycles = 0;
    row_t                    rows [19];
    row_t                    r;
    logic [15:0]             rd;
    logic                    oe;
    logic                    cs;
    logic                    rel;

    always #4 clk = ~clk;

    isa_slave_bus_interface DUT (
        .clk(clk), .arst_n(arst_n), .pinsIn(pins), .resetPin(resetPin),
        .irqEvent(irqEvent), .dmaWant(dmaWant), .sdOut(sdOut),
        .sdOe(sdOe), .memCs16Out(memCs16Out), .memCs16Oe(memCs16Oe),
        .ioCs16Out(ioCs16Out), .ioCs16Oe(ioCs16Oe), .chRdyOut(chRdyOut),
        .chRdyOe(chRdyOe), .irqOut(irqOut), .irqOe(irqOe),
        .dmaReqOut(dmaReqOut), .dmaReqOe(dmaReqOe),
        .scanShiftClk(scanShiftClk), .coreReset(coreReset));

    isa_host_model host (
        .clk(clk), .sdOut(sdOut), .sdOe(sdOe), .memCs16Oe(memCs16Oe),
        .ioCs16Oe(ioCs16Oe), .pins(pins));

    task automatic endSim();
        $display("compared %0d, mismatched %0d", samplesChecked, mismatches);
        if (mismatches == 0 && samplesChecked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // a hang is cut short well past the expected run length
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            mismatches++;
            endSim();
        end
    end

    initial begin
        // flags 6: address enable low, no refresh, normal mode, selected
        // sel: chip-selects decode the address even while refresh masks
        rows = '{'{2'h1, IOB + 20'h0000C, 4'h6, 16'h5A3C, 1'b1, 1'b1},
                 '{2'h0, IOB + 20'h0000C, 4'h6, 16'h5A3C, 1'b1, 1'b1},
                 '{2'h1, IOB + 20'h0000C, 4'h2, 16'h1111, 1'b0, 1'b1},
                 '{2'h1, IOB + 20'h0000C, 4'hE, 16'h2222, 1'b0, 1'b0},
                 '{2'h0, IOB + 20'h0000C, 4'h6, 16'h5A3C, 1'b1, 1'b1},
                 '{2'h0, IOB + 20'h0000C, 4'hE, 16'h0000, 1'b0, 1'b0},
                 '{2'h0, IOB + 20'h0000C, 4'h2, 16'h0000, 1'b0, 1'b1},
                 '{2'h0, IOB + 20'h0000C, 4'h4, 16'h0000, 1'b0, 1'b0},
                 '{2'h0, IOB + 20'hF000C, 4'h6, 16'h5A3C, 1'b1, 1'b1},
                 '{2'h0, IOB + 20'h00010, 4'h6, 16'h0000, 1'b0, 1'b0},
                 '{2'h0, IOB - 20'h00002, 4'h6, 16'h0000, 1'b0, 1'b0},
                 '{2'h3, MB + 20'h00004, 4'h6, 16'hBEEF, 1'b0, 1'b0},
                 '{2'h1, IOB + 20'h00002, 4'h6, 16'h0400, 1'b1, 1'b1},
                 '{2'h3, MB + 20'h00004, 4'h6, 16'hBEEF, 1'b1, 1'b1},
                 '{2'h2, MB + 20'h00004, 4'h6, 16'hBEEF, 1'b1, 1'b1},
                 '{2'h2, MB + 20'h00004, 4'h7, 16'h0000, 1'b0, 1'b0},
                 '{2'h2, MB + 20'h01004, 4'h6, 16'h0000, 1'b0, 1'b0},
                 '{2'h3, MB + 20'h00004, 4'h2, 16'h0000, 1'b0, 1'b1},
                 '{2'h2, MB + 20'h00004, 4'h6, 16'hBEEF, 1'b1, 1'b1}};
        arst_n = 1'b0;
        resetPin = 1'b0;
        irqEvent = 1'b0;
        dmaWant = 1'b0;
        repeat (4) @(negedge clk);
        arst_n = 1'b1;
        host.arm();
        for (int i = 0; i < 19; i++) begin
            r = rows[i];
            host.access(r.op, r.addr, r.flags, r.data, rd, oe, cs, rel);
            `CHECK(cs, r.sel)
            `CHECK(oe, r.hit & ~r.op[0])
            if (r.hit && !r.op[0]) begin
                `CHECK(rd, r.data)
            end
            `CHECK(rel, 1'b0)
            $display("row %0d done", i);
        end
        `CHECK({memCs16Out, ioCs16Out}, 2'b00)
        `CHECK({chRdyOe, chRdyOut}, 2'b00)
        $display("table done");
        // one interrupt and at most one DMA line, chosen by the select register
        irqEvent = 1'b1;
        dmaWant = 1'b1;
        repeat (4) @(negedge clk);
        `CHECK(irqOe, 4'h1)
        `CHECK(dmaReqOe, 3'h0)
        host.access(2'h1, IOB + 20'h00004, 4'h6, 16'h0012, rd, oe, cs, rel);
        `CHECK({irqOe, irqOut}, 8'h44)
        `CHECK({dmaReqOe, dmaReqOut}, 6'h12)
        $display("select test done");
        // pointer at byte 4 reaches the word the memory rows wrote
        host.access(2'h1, IOB + 20'h00008, 4'h6, 16'h0004, rd, oe, cs, rel);
        host.access(2'h0, IOB + 20'h0000A, 4'h6, 16'h0000, rd, oe, cs, rel);
        `CHECK(rd, 16'hBEEF)
        $display("data port test done");
        @(negedge clk);
        host.drv.test_n = 1'b0;
        host.drv.aen = 1'b1;
        repeat (5) @(negedge clk);
        `CHECK(scanShiftClk, 1'b1)
        host.drv.aen = 1'b0;
        repeat (5) @(negedge clk);
        `CHECK(scanShiftClk, 1'b0)
        host.drv.test_n = 1'b1;
        host.drv.aen = 1'b1;
        repeat (5) @(negedge clk);
        `CHECK(scanShiftClk, 1'b0)
        host.drv.aen = 1'b0;
        $display("scan test done");
        // pin must stand 50 clocks past the synchroniser before it counts
        resetPin = 1'b1;
        repeat (45) @(negedge clk);
        `CHECK(coreReset, 1'b0)
        repeat (15) @(negedge clk);
        `CHECK(coreReset, 1'b1)
        resetPin = 1'b0;
        repeat (8) @(negedge clk);
        `CHECK(coreReset, 1'b0)
        `CHECK(irqOe, 4'h1)
        host.access(2'h0, IOB + 20'h00002, 4'h6, 16'h0000, rd, oe, cs, rel);
        `CHECK({cs, oe}, 2'b00)
        host.arm();
        host.access(2'h0, IOB + 20'h00002, 4'h6, 16'h0000, rd, oe, cs, rel);
        `CHECK({cs, oe}, 2'b11)
        `CHECK(rd, isa_slave_pkg::BUS_CTL_RST)
        $display("bus reset test done");
        endSim();
    end
endmodule
